// file: shared/amc_params.svh
// Register map, field layout and arithmetic constants of the calibration block
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Paging
// ----------------------------------------------------------------------------
`define AMC_PAGE_ADDR       8'h00
`define AMC_CAL_PAGE        16'h0002
`define AMC_PAGE_RESET      16'h0000

// ----------------------------------------------------------------------------
// Byte offsets inside the calibration page
// ----------------------------------------------------------------------------
`define AMC_OFS_ACC_X_GAIN  8'h0a
`define AMC_OFS_ACC_Y_GAIN  8'h0c
`define AMC_OFS_ACC_Z_GAIN  8'h0e
`define AMC_OFS_ACC_X_FINE  8'h1c
`define AMC_OFS_ACC_X_CRS   8'h1e
`define AMC_OFS_ACC_Y_FINE  8'h20
`define AMC_OFS_ACC_Y_CRS   8'h22
`define AMC_OFS_ACC_Z_FINE  8'h24
`define AMC_OFS_ACC_Z_CRS   8'h26
`define AMC_OFS_MAG_X_FIX   8'h28
`define AMC_OFS_MAG_Y_FIX   8'h2a
`define AMC_OFS_MAG_Z_FIX   8'h2c
`define AMC_OFS_MAG_XX      8'h2e
`define AMC_OFS_MAG_XY      8'h30
`define AMC_OFS_MAG_XZ      8'h32
`define AMC_OFS_MAG_YX      8'h34
`define AMC_OFS_MAG_YY      8'h36
`define AMC_OFS_MAG_YZ      8'h38
`define AMC_OFS_MAG_ZX      8'h3a
`define AMC_OFS_MAG_ZY      8'h3c
`define AMC_OFS_MAG_ZZ      8'h3e

// ----------------------------------------------------------------------------
// Word indices in the calibration store
// ----------------------------------------------------------------------------
`define AMC_IDX_ACC_X_GAIN  5'd0
`define AMC_IDX_ACC_Y_GAIN  5'd1
`define AMC_IDX_ACC_Z_GAIN  5'd2
`define AMC_IDX_ACC_X_FINE  5'd3
`define AMC_IDX_ACC_X_CRS   5'd4
`define AMC_IDX_ACC_Y_FINE  5'd5
`define AMC_IDX_ACC_Y_CRS   5'd6
`define AMC_IDX_ACC_Z_FINE  5'd7
`define AMC_IDX_ACC_Z_CRS   5'd8
`define AMC_IDX_MAG_X_FIX   5'd9
`define AMC_IDX_MAG_Y_FIX   5'd10
`define AMC_IDX_MAG_Z_FIX   5'd11
`define AMC_IDX_MAG_XX      5'd12
`define AMC_IDX_MAG_XY      5'd13
`define AMC_IDX_MAG_XZ      5'd14
`define AMC_IDX_MAG_YX      5'd15
`define AMC_IDX_MAG_YY      5'd16
`define AMC_IDX_MAG_YZ      5'd17
`define AMC_IDX_MAG_ZX      5'd18
`define AMC_IDX_MAG_ZY      5'd19
`define AMC_IDX_MAG_ZZ      5'd20
`define AMC_NUM_WORDS       21

// ----------------------------------------------------------------------------
// Reset values and arithmetic
// ----------------------------------------------------------------------------
`define AMC_CAL_RESET       16'h0000
`define AMC_UNITY_SHIFT     15

`endif

// file: shared/amc_pkg.sv
// Types shared by the calibration block and its bench
package amc_pkg;

  typedef struct packed {
    logic signed [31:0] x;
    logic signed [31:0] y;
    logic signed [31:0] z;
  } amc_acc_s;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } amc_mag_s;

  typedef logic [4:0]  amc_idx_t;
  typedef logic [15:0] amc_word_t;

endpackage

// file: rtl/amc_calib.sv
// Accelerometer and magnetometer user calibration datapath with paged registers
`timescale 1ns/1ps
`include "amc_params.svh"

module amc_calib (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  output      logic [15:0]      reg_rdata,
  input  wire logic             sample_valid,
  input  wire amc_pkg::amc_acc_s acc_raw,
  input  wire amc_pkg::amc_mag_s mag_raw,
  output      logic             cal_valid,
  output      amc_pkg::amc_acc_s acc_cal,
  output      amc_pkg::amc_mag_s mag_cal
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic [5:0] word_of(input logic [7:0] a);
    logic [5:0] r;
    r = 6'h00;
    if (a == `AMC_OFS_ACC_X_GAIN) r = {1'b1, `AMC_IDX_ACC_X_GAIN};
    else if (a == `AMC_OFS_ACC_Y_GAIN) r = {1'b1, `AMC_IDX_ACC_Y_GAIN};
    else if (a == `AMC_OFS_ACC_Z_GAIN) r = {1'b1, `AMC_IDX_ACC_Z_GAIN};
    else if (a == `AMC_OFS_ACC_X_FINE) r = {1'b1, `AMC_IDX_ACC_X_FINE};
    else if (a == `AMC_OFS_ACC_X_CRS)  r = {1'b1, `AMC_IDX_ACC_X_CRS};
    else if (a == `AMC_OFS_ACC_Y_FINE) r = {1'b1, `AMC_IDX_ACC_Y_FINE};
    else if (a == `AMC_OFS_ACC_Y_CRS)  r = {1'b1, `AMC_IDX_ACC_Y_CRS};
    else if (a == `AMC_OFS_ACC_Z_FINE) r = {1'b1, `AMC_IDX_ACC_Z_FINE};
    else if (a == `AMC_OFS_ACC_Z_CRS)  r = {1'b1, `AMC_IDX_ACC_Z_CRS};
    else if (a == `AMC_OFS_MAG_X_FIX)  r = {1'b1, `AMC_IDX_MAG_X_FIX};
    else if (a == `AMC_OFS_MAG_Y_FIX)  r = {1'b1, `AMC_IDX_MAG_Y_FIX};
    else if (a == `AMC_OFS_MAG_Z_FIX)  r = {1'b1, `AMC_IDX_MAG_Z_FIX};
    else if (a == `AMC_OFS_MAG_XX)     r = {1'b1, `AMC_IDX_MAG_XX};
    else if (a == `AMC_OFS_MAG_XY)     r = {1'b1, `AMC_IDX_MAG_XY};
    else if (a == `AMC_OFS_MAG_XZ)     r = {1'b1, `AMC_IDX_MAG_XZ};
    else if (a == `AMC_OFS_MAG_YX)     r = {1'b1, `AMC_IDX_MAG_YX};
    else if (a == `AMC_OFS_MAG_YY)     r = {1'b1, `AMC_IDX_MAG_YY};
    else if (a == `AMC_OFS_MAG_YZ)     r = {1'b1, `AMC_IDX_MAG_YZ};
    else if (a == `AMC_OFS_MAG_ZX)     r = {1'b1, `AMC_IDX_MAG_ZX};
    else if (a == `AMC_OFS_MAG_ZY)     r = {1'b1, `AMC_IDX_MAG_ZY};
    else if (a == `AMC_OFS_MAG_ZZ)     r = {1'b1, `AMC_IDX_MAG_ZZ};
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Correction arithmetic
  // --------------------------------------------------------------------------
  function automatic logic signed [31:0] acc_fix(input logic signed [31:0] raw,
                                                 input logic signed [15:0] gain,
                                                 input logic signed [15:0] crs,
                                                 input logic signed [15:0] fine);
    logic signed [47:0] prod;
    logic signed [49:0] sum;
    prod = raw * gain;
    sum  = 50'(raw) + 50'(prod >>> `AMC_UNITY_SHIFT)
         + 50'($signed({crs, 16'h0000})) + 50'(fine);
    if (sum[49:31] != {19{sum[49]}}) begin
      acc_fix = sum[49] ? 32'h80000000 : 32'h7fffffff;
    end else begin
      acc_fix = sum[31:0];
    end
  endfunction

  function automatic logic signed [15:0] mag_fix(input logic signed [15:0] self,
                                                 input amc_pkg::amc_mag_s m,
                                                 input logic signed [15:0] s0,
                                                 input logic signed [15:0] s1,
                                                 input logic signed [15:0] s2,
                                                 input logic signed [15:0] hard);
    logic signed [35:0] row;
    logic signed [35:0] tot;
    row = 36'(m.x * s0) + 36'(m.y * s1) + 36'(m.z * s2);
    tot = 36'(self) + (row >>> `AMC_UNITY_SHIFT) + 36'(hard);
    if (tot[35:15] != {21{tot[35]}}) begin
      mag_fix = tot[35] ? 16'h8000 : 16'h7fff;
    end else begin
      mag_fix = tot[15:0];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  amc_pkg::amc_word_t cal_q      [`AMC_NUM_WORDS];
  amc_pkg::amc_word_t next_cal   [`AMC_NUM_WORDS];
  logic [15:0]        page;
  logic [15:0]        next_page;
  logic [15:0]        next_rdata;
  logic [5:0]         hit;
  logic               on_cal_page;

  assign hit         = word_of(reg_addr);
  assign on_cal_page = (page == `AMC_CAL_PAGE);

  always_comb begin
    next_page = page;
    for (int i = 0; i < `AMC_NUM_WORDS; i++) begin
      next_cal[i] = cal_q[i];
    end
    if (reg_wr) begin
      if (reg_addr == `AMC_PAGE_ADDR) begin
        next_page = reg_wdata;
      end else if (on_cal_page && hit[5]) begin
        next_cal[hit[4:0]] = reg_wdata;
      end
    end
    next_rdata = reg_rdata;
    if (reg_rd) begin
      if (reg_addr == `AMC_PAGE_ADDR) begin
        next_rdata = page;
      end else if (on_cal_page && hit[5]) begin
        next_rdata = cal_q[hit[4:0]];
      end else begin
        next_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      page      <= `AMC_PAGE_RESET;
      reg_rdata <= 16'h0000;
      for (int i = 0; i < `AMC_NUM_WORDS; i++) begin
        cal_q[i] <= `AMC_CAL_RESET;
      end
    end else begin
      page      <= next_page;
      reg_rdata <= next_rdata;
      for (int i = 0; i < `AMC_NUM_WORDS; i++) begin
        cal_q[i] <= next_cal[i];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sample path
  // --------------------------------------------------------------------------
  amc_pkg::amc_acc_s next_acc;
  amc_pkg::amc_mag_s next_mag;

  always_comb begin
    next_acc   = acc_cal;
    next_mag   = mag_cal;
    if (sample_valid) begin
      next_acc.x = acc_fix(acc_raw.x, cal_q[`AMC_IDX_ACC_X_GAIN],
                           cal_q[`AMC_IDX_ACC_X_CRS], cal_q[`AMC_IDX_ACC_X_FINE]);
      next_acc.y = acc_fix(acc_raw.y, cal_q[`AMC_IDX_ACC_Y_GAIN],
                           cal_q[`AMC_IDX_ACC_Y_CRS], cal_q[`AMC_IDX_ACC_Y_FINE]);
      next_acc.z = acc_fix(acc_raw.z, cal_q[`AMC_IDX_ACC_Z_GAIN],
                           cal_q[`AMC_IDX_ACC_Z_CRS], cal_q[`AMC_IDX_ACC_Z_FINE]);
      next_mag.x = mag_fix(mag_raw.x, mag_raw, cal_q[`AMC_IDX_MAG_XX],
                           cal_q[`AMC_IDX_MAG_XY], cal_q[`AMC_IDX_MAG_XZ],
                           cal_q[`AMC_IDX_MAG_X_FIX]);
      next_mag.y = mag_fix(mag_raw.y, mag_raw, cal_q[`AMC_IDX_MAG_YX],
                           cal_q[`AMC_IDX_MAG_YY], cal_q[`AMC_IDX_MAG_YZ],
                           cal_q[`AMC_IDX_MAG_Y_FIX]);
      next_mag.z = mag_fix(mag_raw.z, mag_raw, cal_q[`AMC_IDX_MAG_ZX],
                           cal_q[`AMC_IDX_MAG_ZY], cal_q[`AMC_IDX_MAG_ZZ],
                           cal_q[`AMC_IDX_MAG_Z_FIX]);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cal_valid <= 1'b0;
      acc_cal   <= '0;
      mag_cal   <= '0;
    end else begin
      cal_valid <= sample_valid;
      acc_cal   <= next_acc;
      mag_cal   <= next_mag;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic cal_all_zero;
  logic soft_zero;

  always_comb begin
    cal_all_zero = 1'b1;
    soft_zero    = 1'b1;
    for (int i = 0; i < `AMC_NUM_WORDS; i++) begin
      if (cal_q[i] != 16'h0000) begin
        cal_all_zero = 1'b0;
      end
      if (i >= 12 && cal_q[i] != 16'h0000) begin
        soft_zero = 1'b0;
      end
    end
  end

  chk_fine_offset: assert property (@(posedge clock) disable iff (sys_rst)
    sample_valid && acc_raw.z == 32'sh0 && cal_q[`AMC_IDX_ACC_Z_CRS] == 16'h0000
    |=> acc_cal.z == 32'($signed($past(cal_q[`AMC_IDX_ACC_Z_FINE]))))
    else $error("fine offset not applied as signed word");

  chk_gain_step: assert property (@(posedge clock) disable iff (sys_rst)
    sample_valid && acc_raw.x == 32'sh00008000
    && cal_q[`AMC_IDX_ACC_X_CRS] == 16'h0000 && cal_q[`AMC_IDX_ACC_X_FINE] == 16'h0000
    |=> acc_cal.x == 32'sh00008000 + 32'($signed($past(cal_q[`AMC_IDX_ACC_X_GAIN]))))
    else $error("gain step is not one part in 32768");

  chk_axis_isolate: assert property (@(posedge clock) disable iff (sys_rst)
    sample_valid && cal_q[`AMC_IDX_ACC_Y_GAIN] == 16'h0000
    && cal_q[`AMC_IDX_ACC_Y_CRS] == 16'h0000 && cal_q[`AMC_IDX_ACC_Y_FINE] == 16'h0000
    |=> cal_valid && acc_cal.y == $past(acc_raw.y))
    else $error("y axis changed by another axis word");

  chk_mag_pass: assert property (@(posedge clock) disable iff (sys_rst)
    sample_valid && soft_zero && cal_q[`AMC_IDX_MAG_Z_FIX] == 16'h0000
    |=> mag_cal.z == $past(mag_raw.z))
    else $error("identity matrix does not pass z through");

  chk_hard_offset: assert property (@(posedge clock) disable iff (sys_rst)
    sample_valid && soft_zero && mag_raw.x == 16'sh0
    |=> mag_cal.x == $past(cal_q[`AMC_IDX_MAG_X_FIX]))
    else $error("fixed offset not added to x");

  chk_align_term: assert property (@(posedge clock) disable iff (sys_rst)
    sample_valid && mag_raw == {16'sh8000, 16'sh0, 16'sh0}
    && cal_q[`AMC_IDX_MAG_Y_FIX] == 16'h0000 && cal_q[`AMC_IDX_MAG_YX] != 16'h8000
    |=> mag_cal.y == -$signed($past(cal_q[`AMC_IDX_MAG_YX])))
    else $error("cross term from x into y wrong");

  chk_reset_zero: assert property (@(posedge clock)
    sys_rst |=> cal_all_zero && !cal_valid && page == `AMC_PAGE_RESET)
    else $error("correction words not zero after reset");

  chk_sat_high: assert property (@(posedge clock) disable iff (sys_rst)
    sample_valid && acc_raw.x == 32'sh7fffffff && cal_q[`AMC_IDX_ACC_X_GAIN] == 16'h0000
    && !cal_q[`AMC_IDX_ACC_X_CRS][15] && cal_q[`AMC_IDX_ACC_X_CRS] != 16'h0000
    |=> acc_cal.x == 32'sh7fffffff)
    else $error("positive overflow not saturated");

  chk_page_gate: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd && reg_addr != `AMC_PAGE_ADDR && !on_cal_page |=> reg_rdata == 16'h0000)
    else $error("calibration word visible off its page");

endmodule

// file: dv/amc_calib_tb_top.sv
// Self-checking bench for the calibration datapath with an integer reference model
`timescale 1ns/1ps
`include "amc_params.svh"

module amc_calib_tb_top;
  logic              clock;
  logic              sys_rst;
  logic              reg_wr;
  logic              reg_rd;
  logic              sample_valid;
  logic              cal_valid;
  logic [7:0]        reg_addr;
  logic [15:0]       reg_wdata;
  logic [15:0]       reg_rdata;
  amc_pkg::amc_acc_s acc_raw;
  amc_pkg::amc_acc_s acc_cal;
  amc_pkg::amc_mag_s mag_raw;
  amc_pkg::amc_mag_s mag_cal;
  int                fails;
  int                samples_checked;
  logic [15:0]       mm [0:255];
  logic [15:0]       page;
  logic [63:0]       t;

  amc_calib amc_calib_i (
    .clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .acc_raw(acc_raw), .mag_raw(mag_raw),
    .cal_valid(cal_valid), .acc_cal(acc_cal), .mag_cal(mag_cal)
  );

  initial clock = 1'b0;
  always #2 clock = ~clock;

  // ---------------------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------------------
  function automatic bit mapped(logic [7:0] a);
    return !a[0] && ((a >= 8'h0a && a <= 8'h0e) || (a >= 8'h1c && a <= 8'h3e));
  endfunction

  function automatic longint sw(logic [7:0] a);
    return longint'($signed(mm[a]));
  endfunction

  function automatic logic [31:0] acc_m(longint r, longint g, longint c, longint f);
    longint v;
    v = r + ((r * g) >>> 15) + (c * 65536) + f;
    if (v > 64'sh000000007fffffff) v = 64'sh000000007fffffff;
    if (v < -64'sh0000000080000000) v = -64'sh0000000080000000;
    return v[31:0];
  endfunction

  function automatic logic [15:0] mag_m(longint r, longint r0, longint r1, longint r2,
                                        longint s0, longint s1, longint s2, longint h);
    longint v;
    v = r + ((s0 * r0 + s1 * r1 + s2 * r2) >>> 15) + h;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  task automatic m_reset();
    page = 16'h0000;
    for (int i = 0; i < 256; i++) mm[i] = 16'h0000;
  endtask

  // ---------------------------------------------------------------------------
  // Drivers and compare
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    if (a == `AMC_PAGE_ADDR) page = d;
    else if (page == `AMC_CAL_PAGE && mapped(a)) mm[a] = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    logic [15:0] e;
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    e = (page == `AMC_CAL_PAGE && mapped(a)) ? mm[a] : 16'h0000;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    chk({80'h0, reg_rdata}, {80'h0, e});
  endtask

  task automatic rd_all();
    for (int a = 2; a <= 8'h40; a += 2) rd(a[7:0]);
  endtask

  task automatic smp(input logic [95:0] a, input logic [47:0] m);
    amc_pkg::amc_acc_s ea;
    amc_pkg::amc_mag_s em;
    @(posedge clock);
    #1;
    sample_valid = 1'b1;
    acc_raw = a;
    mag_raw = m;
    ea.x = acc_m(acc_raw.x, sw(`AMC_OFS_ACC_X_GAIN), sw(`AMC_OFS_ACC_X_CRS), sw(`AMC_OFS_ACC_X_FINE));
    ea.y = acc_m(acc_raw.y, sw(`AMC_OFS_ACC_Y_GAIN), sw(`AMC_OFS_ACC_Y_CRS), sw(`AMC_OFS_ACC_Y_FINE));
    ea.z = acc_m(acc_raw.z, sw(`AMC_OFS_ACC_Z_GAIN), sw(`AMC_OFS_ACC_Z_CRS), sw(`AMC_OFS_ACC_Z_FINE));
    em.x = mag_m(mag_raw.x, mag_raw.x, mag_raw.y, mag_raw.z, sw(`AMC_OFS_MAG_XX),
                 sw(`AMC_OFS_MAG_XY), sw(`AMC_OFS_MAG_XZ), sw(`AMC_OFS_MAG_X_FIX));
    em.y = mag_m(mag_raw.y, mag_raw.x, mag_raw.y, mag_raw.z, sw(`AMC_OFS_MAG_YX),
                 sw(`AMC_OFS_MAG_YY), sw(`AMC_OFS_MAG_YZ), sw(`AMC_OFS_MAG_Y_FIX));
    em.z = mag_m(mag_raw.z, mag_raw.x, mag_raw.y, mag_raw.z, sw(`AMC_OFS_MAG_ZX),
                 sw(`AMC_OFS_MAG_ZY), sw(`AMC_OFS_MAG_ZZ), sw(`AMC_OFS_MAG_Z_FIX));
    @(posedge clock);
    #1;
    sample_valid = 1'b0;
    acc_raw = ~acc_raw;
    mag_raw = ~mag_raw;
    chk({95'h0, cal_valid}, {95'h0, 1'b1});
    chk(acc_cal, ea);
    chk({48'h0, mag_cal}, {48'h0, em});
    @(posedge clock);
    #1;
    chk({95'h0, cal_valid}, 96'h0);
    chk(acc_cal, ea);
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {sys_rst, reg_wr, reg_rd, sample_valid} = 4'b1000;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    acc_raw = '0;
    mag_raw = '0;
    fails = 0;
    samples_checked = 0;
    m_reset();
    void'($urandom(73));
    repeat (8) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    rd(`AMC_OFS_MAG_X_FIX);
    wr(`AMC_OFS_MAG_X_FIX, 16'h1234);
    wr(`AMC_PAGE_ADDR, `AMC_CAL_PAGE);
    rd_all();
    t = {$urandom, $urandom};
    smp({$urandom, $urandom, $urandom}, t[47:0]);
    wr(`AMC_OFS_MAG_X_FIX, 16'h7fff);
    wr(`AMC_OFS_MAG_Y_FIX, 16'hffff);
    wr(`AMC_OFS_MAG_Z_FIX, 16'h8000);
    smp(96'h0, 48'h0);
    chk({48'h0, mag_cal}, {48'h0, 16'h7fff, 16'hffff, 16'h8000});
    smp(96'h0, {16'h0001, 16'h0000, 16'hffff});
    for (int n = 0; n < 12; n++) begin
      for (int a = 8'h0a; a <= 8'h3e; a += 2) begin
        if (mapped(a[7:0])) wr(a[7:0], 16'($urandom));
      end
      rd_all();
      t = {$urandom, $urandom};
      smp({$urandom, $urandom, $urandom}, t[47:0]);
      smp({32'h7fffffff, 32'h80000000, $urandom}, 48'h7fff80007fff);
    end
    wr(`AMC_OFS_ACC_X_GAIN, 16'($urandom));
    wr(`AMC_OFS_ACC_X_CRS, 16'h0000);
    wr(`AMC_OFS_ACC_X_FINE, 16'h0000);
    wr(`AMC_OFS_ACC_Z_CRS, 16'h0000);
    wr(`AMC_OFS_MAG_Y_FIX, 16'h0000);
    smp({32'h00008000, $urandom, 32'h00000000}, 48'h800000000000);
    wr(`AMC_OFS_ACC_X_GAIN, 16'h0000);
    wr(`AMC_OFS_ACC_X_CRS, (16'($urandom) & 16'h7fff) | 16'h0001);
    t = {$urandom, $urandom};
    smp({32'h7fffffff, $urandom, $urandom}, t[47:0]);
    wr(`AMC_PAGE_ADDR, 16'h0000);
    wr(`AMC_OFS_ACC_Z_FINE, 16'h5a5a);
    rd(`AMC_OFS_ACC_Z_FINE);
    wr(`AMC_PAGE_ADDR, `AMC_CAL_PAGE);
    rd(`AMC_OFS_ACC_Z_FINE);
    @(posedge clock);
    #1;
    sys_rst = 1'b1;
    m_reset();
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk({acc_cal[95:1], cal_valid}, 96'h0);
    chk({48'h0, mag_cal}, 96'h0);
    chk({80'h0, reg_rdata}, 96'h0);
    wr(`AMC_PAGE_ADDR, `AMC_CAL_PAGE);
    rd_all();
    smp({$urandom, $urandom, $urandom}, 48'h123487650fed);
    print_verdict();
  end

  initial begin
    #50000;
    fails++;
    print_verdict();
  end
endmodule
